// *** bench/pmp_mac_model.sv ***
// behavioural mac facing the mii/rmii data port
module pmp_mac_model
(
  input wire logic clk_sys,
  input wire logic rmii,
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er,
  output logic tx_en,
  output logic [3:0] txd
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] tx_q[$];
  logic [4:0] rx_q[$];
  logic tck_q = 0;
  logic rck_q = 0;
  logic hi_q = 0;
  logic [3:0] cur;
  initial
  begin
    tx_en = 0;
    txd = 0;
  end
  // ---------------------------------------------------------------
  // clock edges seen at negedge, pins moved 1 ns after the next posedge
  // ---------------------------------------------------------------
  always @(negedge clk_sys)
  begin
    tck_q <= tx_clk;
    rck_q <= rx_clk;
    if (tx_clk && !tck_q)
    begin
      if (hi_q)
      begin
        txd <= #5 {2'b00, cur[3:2]};
        hi_q <= 0;
      end
      else if (tx_q.size() > 0)
      begin
        cur = tx_q.pop_front();
        tx_en <= #5 1'b1;
        txd <= #5 rmii ? {2'b00, cur[1:0]} : cur;
        hi_q <= rmii;
      end
      else
      begin
        tx_en <= #5 1'b0;
        txd <= #5 ~txd; // idle data is junk, so it must not be trusted
      end
    end
    // receive data is taken on the rising receive clock only
    if (rx_clk && !rck_q && rx_dv)
      rx_q.push_back({rx_er, rxd});
  end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the mac-side data port
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0;
  logic sys_rst = 1;
  logic ref_clock_in = 0;
  logic rec_clk_in = 0;
  logic speed_100 = 1;
  logic full_duplex = 0;
  logic rx_carrier = 0;
  logic rx_in_valid = 0;
  logic rx_in_err = 0;
  logic [3:0] rx_in_data = 0;
  logic [3:0] st_rxd = 0;
  logic st_dv = 1;
  logic st_col = 1;
  logic rx_in_ready, tx_out_stb, tx_active, tx_clk_o, tx_clk_oe, rx_clk_o, rx_clk_oe;
  logic rxd_oe, rx_dv_o, rx_dv_oe, rx_er_o, rx_er_oe, crs_o, crs_oe, col_o, col_oe;
  logic rmii_mode, xover, ind_cfg, tx_en;
  logic [3:0] tx_out_data, txd, rxd_o;
  logic [4:0] phy_addr;
  logic [3:0] txg[$];
  logic [7:0] tx_per = 0, rx_per = 0, tx_lag = 0, txc = 0, rxc = 0, refc = 0;
  logic tq = 0, rq = 0, fq = 0;
  int error_cnt = 0;
  int total_checks = 0;
  // released shared pins fall back to their strap or pull level
  wire logic [3:0] rxd_w = rxd_oe ? rxd_o : st_rxd;
  wire logic dv_w = rx_dv_oe ? rx_dv_o : st_dv;
  wire logic er_w = rx_er_oe ? rx_er_o : 1'b1;
  wire logic crs_w = crs_oe ? crs_o : 1'b1;
  wire logic col_w = col_oe ? col_o : st_col;
  pmp_port dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1), .ref_clock_in(ref_clock_in),
    .rec_clk_in(rec_clk_in), .speed_100(speed_100), .full_duplex(full_duplex), .rx_carrier(rx_carrier),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in_data(rx_in_data), .rx_in_err(rx_in_err),
    .tx_out_data(tx_out_data), .tx_out_stb(tx_out_stb), .tx_active(tx_active), .tx_clk_o(tx_clk_o),
    .tx_clk_oe(tx_clk_oe), .rx_clk_o(rx_clk_o), .rx_clk_oe(rx_clk_oe), .tx_en(tx_en), .txd(txd),
    .rxd_i(rxd_w), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .rx_dv_i(dv_w), .rx_dv_o(rx_dv_o), .rx_dv_oe(rx_dv_oe),
    .rx_er_i(er_w), .rx_er_o(rx_er_o), .rx_er_oe(rx_er_oe), .crs_i(crs_w), .crs_o(crs_o), .crs_oe(crs_oe),
    .col_i(col_w), .col_o(col_o), .col_oe(col_oe), .phy_addr(phy_addr), .rmii_mode(rmii_mode),
    .strap_crossover_enable(xover), .strap_indicator_config(ind_cfg));
  // in rmii the mac times both directions from the reference; released clock pins read low
  pmp_mac_model mac_u (.clk_sys(clk_sys), .rmii(rmii_mode),
    .tx_clk(rmii_mode ? ref_clock_in : (tx_clk_oe & tx_clk_o)),
    .rx_clk(rmii_mode ? ref_clock_in : (rx_clk_oe & rx_clk_o)),
    .rxd(rxd_o), .rx_dv(rx_dv_o), .rx_er(rx_er_o), .tx_en(tx_en), .txd(txd));
  // ---------------------------------------------------------------
  // clocks and edge monitors
  // ---------------------------------------------------------------
  initial forever #4 clk_sys = ~clk_sys;
  initial #3 forever #32 ref_clock_in = ~ref_clock_in;
  initial #5 forever #36 rec_clk_in = ~rec_clk_in;
  // sampled at negedge so registered outputs have settled
  always @(negedge clk_sys)
  begin
    txc++;
    rxc++;
    refc++;
    if (ref_clock_in && !fq)
      refc = 0;
    if (tx_clk_o && !tq)
    begin
      tx_per = txc;
      tx_lag = refc;
      txc = 0;
    end
    if (rx_clk_o && !rq)
    begin
      rx_per = rxc;
      rxc = 0;
    end
    if (tx_out_stb === 1'b1)
      txg.push_back(tx_out_data);
    tq = tx_clk_o;
    rq = rx_clk_o;
    fq = ref_clock_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic do_reset(input logic dv, input logic [3:0] ad, input logic c);
    st_dv = dv;
    st_rxd = ad;
    st_col = c;
    sys_rst = 1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({rxd_oe, rx_dv_oe, rx_er_oe, crs_oe, col_oe, tx_clk_oe, rx_clk_oe}, 0, "oe in reset");
    sys_rst = 0;
    repeat (6) @(posedge clk_sys) #1;
    chk({rxd_oe, rx_dv_oe, rx_er_oe, crs_oe}, 4'hf, "oe after window");
    chk(phy_addr, {ad, c}, "address");
    chk({rmii_mode, xover, ind_cfg}, {!dv, 2'b11}, "mode straps");
    $display("test reset done");
  endtask
  task automatic test_clocks();
    logic [7:0] lag;
    repeat (40) @(posedge clk_sys);
    lag = tx_lag;
    chk(tx_per, 8, "tx period 100");
    chk(rx_per, 9, "rx period 100");
    chk({tx_clk_oe, rx_clk_oe}, 3, "clock oe");
    repeat (40) @(posedge clk_sys);
    chk(tx_lag, lag, "tx phase 100");
    speed_100 = 0;
    repeat (400) @(posedge clk_sys);
    lag = tx_lag;
    chk(tx_per, 80, "tx period 10");
    chk(rx_per, 90, "rx period 10");
    repeat (200) @(posedge clk_sys);
    chk(tx_lag, lag, "tx phase 10");
    speed_100 = 1;
    repeat (200) @(posedge clk_sys) #1;
    $display("test clocks done");
  endtask
  // holds the word until ready is seen high at a sampling edge
  task automatic push(input logic [3:0] d, input logic e, inout int refused);
    int k;
    rx_in_valid = 1;
    rx_in_data = d;
    rx_in_err = e;
    for (k = 0; rx_in_ready !== 1'b1 && k < 400; k++) @(posedge clk_sys) #1;
    chk(k < 400, 1, "ready timeout");
    if (k > 0)
      refused++;
    @(posedge clk_sys) #1;
  endtask
  task automatic test_rx(input logic rm);
    logic [3:0] w[4] = '{4'h3, 4'hc, 4'h6, 4'h9};
    logic [4:0] exp[$];
    logic [3:0] nib;
    logic e;
    int k, refused, bad;
    refused = 0;
    bad = 0;
    mac_u.rx_q.delete();
    rx_carrier = 1;
    for (k = 0; k < 4; k++)
    begin
      e = (k == 2);
      push(w[k], e, refused);
      nib = e ? ~w[k] : w[k];
      if (rm)
      begin
        exp.push_back({e, 2'b00, nib[1:0]});
        exp.push_back({e, 2'b00, nib[3:2]});
      end
      else
        exp.push_back({e, nib});
    end
    rx_in_valid = 0;
    chk(crs_o, 1, "carrier on");
    // in rmii the carrier drops mid-frame, so the pin must hold up on valid alone
    rx_carrier = !rm;
    chk(refused > 0, 1, "buffer full");
    for (k = 0; mac_u.rx_q.size() < exp.size() && k < 3000; k++)
    begin
      @(posedge clk_sys) #1;
      if (rm && rx_dv_o === 1'b1 && crs_o !== 1'b1)
        bad++;
    end
    chk(bad, 0, "combined carrier during valid");
    repeat (30) @(posedge clk_sys) #1;
    chk(rx_dv_o, 0, "valid after frame");
    chk(8'(mac_u.rx_q.size()), 8'(exp.size()), "word count");
    for (k = 0; k < exp.size() && k < mac_u.rx_q.size(); k++)
      chk(mac_u.rx_q[k], exp[k], "rx word");
    rx_carrier = 0;
    repeat (4) @(posedge clk_sys) #1;
    chk(crs_o, 0, "carrier off");
    $display("test receive done");
  endtask
  task automatic test_tx(input logic rm);
    logic [3:0] s[4] = '{4'ha, 4'h5, 4'h3, 4'hc};
    int k;
    txg.delete();
    rx_carrier = 1;
    foreach (s[i]) mac_u.tx_q.push_back(s[i]);
    for (k = 0; tx_active !== 1'b1 && k < 400; k++) @(posedge clk_sys) #1;
    repeat (2) @(posedge clk_sys) #1;
    chk({col_o, col_oe}, {!rm, !rm}, "half duplex collision");
    full_duplex = 1;
    repeat (3) @(posedge clk_sys) #1;
    chk(col_o, 0, "full duplex collision");
    for (k = 0; txg.size() < 4 && k < 2000; k++) @(posedge clk_sys) #1;
    chk(8'(txg.size()), 4, "tx count");
    for (k = 0; k < 4 && k < txg.size(); k++)
      chk(txg[k], s[k], "tx nibble");
    rx_carrier = 0;
    full_duplex = 0;
    $display("test transmit done");
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    #1;
    do_reset(1'b1, 4'h0, 1'b1);
    test_clocks();
    test_rx(1'b0);
    test_tx(1'b0);
    do_reset(1'b0, 4'ha, 1'b0);
    chk({tx_clk_oe, col_oe, rxd_oe}, 1, "rmii oe");
    test_rx(1'b1);
    test_tx(1'b1);
    print_verdict();
  end
  // the run needs under 2k cycles; 40k means something hangs
  initial
  begin
    #320000;
    error_cnt++;
    $display("Error at %0t: timeout", $time);
    print_verdict();
  end
endmodule

// *** verilog/pmp_buf2.sv ***
// two-entry valid/ready buffer
`include "pmp_map.svh"

module pmp_buf2
  import pmp_pkg::*;
#(
  parameter int WIDTH = 5
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  // full and empty come straight from the count
  assign in_ready = (count_q != 2'd2);
  assign out_valid = (count_q != 2'd0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid & in_ready & ce;
  assign pop = out_valid & out_ready & ce;

  // ---------------------------------------------------------------
  // storage, written by index
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

  // ---------------------------------------------------------------
  // pointers and occupancy
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'd0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// *** verilog/pmp_clkgen.sv ***
// clock follower and divider driven by a sampled clock pin
`include "pmp_map.svh"

module pmp_clkgen
  import pmp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic clk_pin,
  input wire logic div10,
  output logic clk_q,
  output logic rise_stb,
  output logic fall_stb
);

  logic [1:0] sync_q;
  logic lvl_q;
  logic [`PMP_DIV_W-1:0] cnt_q;
  logic [`PMP_DIV_W-1:0] cnt_d;
  logic pin_rise;
  logic cnt_last;
  logic clk_d;

  // ---------------------------------------------------------------
  // pin synchroniser and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_q <= 2'h0;
      lvl_q <= 1'b0;
    end
    else if (ce)
    begin
      sync_q <= {sync_q[0], clk_pin};
      lvl_q <= sync_q[1];
    end
  end

  // every output edge comes from a pin edge, so the phase to the pin is fixed
  assign pin_rise = sync_q[1] & ~lvl_q;
  assign cnt_last = (cnt_q == `PMP_DIV10_LAST);
  assign cnt_d = !pin_rise ? cnt_q : (cnt_last ? '0 : cnt_q + `PMP_DIV_W'(1));
  assign clk_d = div10 ? ((pin_rise & cnt_last) ? ~clk_q : clk_q) : sync_q[1];
  assign rise_stb = clk_d & ~clk_q;
  assign fall_stb = ~clk_d & clk_q;

  // ---------------------------------------------------------------
  // divider state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

endmodule

// *** verilog/pmp_map.svh ***
// named constants for the mac-side mii/rmii data port
`ifndef PMP_MAP_SVH
`define PMP_MAP_SVH

// ---------------------------------------------------------------
// clock division and strap timing
// ---------------------------------------------------------------
`define PMP_DIV_W 3
`define PMP_DIV10_LAST 3'd4
`define PMP_STRAP_W 2
`define PMP_STRAP_HOLD 2'd3

// ---------------------------------------------------------------
// data widths, field positions and reset values
// ---------------------------------------------------------------
`define PMP_NIB_W 4
`define PMP_ADDR_W 5
`define PMP_PIN_W 13
`define PMP_RXW_ERR 4
`define PMP_RX_CORRUPT 4'hf
`define PMP_NIB_ZERO 4'h0
`define PMP_SYNC_TXEN 12
`define PMP_SYNC_TXD_HI 11
`define PMP_SYNC_TXD_LO 8
`define PMP_SYNC_COL 7
`define PMP_SYNC_CRS 6
`define PMP_SYNC_ER 5
`define PMP_SYNC_DV 4

`endif

// *** verilog/pmp_pkg.sv ***
// types shared by the mac-side data port
package pmp_pkg;

  // receive-side output sequencing
  typedef enum logic [1:0] {PMP_RX_IDLE, PMP_RX_ACTIVE, PMP_RX_DIB_HI} pmp_rx_st_t;

endpackage

// *** verilog/pmp_port.sv ***
// mac-side mii/rmii data port of a 10/100 phy
`include "pmp_map.svh"

module pmp_port
  import pmp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic ref_clock_in,
  input wire logic rec_clk_in,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic rx_carrier,
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic [3:0] rx_in_data,
  input wire logic rx_in_err,
  output logic [3:0] tx_out_data,
  output logic tx_out_stb,
  output logic tx_active,
  output logic tx_clk_o,
  output logic tx_clk_oe,
  output logic rx_clk_o,
  output logic rx_clk_oe,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic [3:0] rxd_i,
  output logic [3:0] rxd_o,
  output logic rxd_oe,
  input wire logic rx_dv_i,
  output logic rx_dv_o,
  output logic rx_dv_oe,
  input wire logic rx_er_i,
  output logic rx_er_o,
  output logic rx_er_oe,
  input wire logic crs_i,
  output logic crs_o,
  output logic crs_oe,
  input wire logic col_i,
  output logic col_o,
  output logic col_oe,
  output logic [4:0] phy_addr,
  output logic rmii_mode,
  output logic strap_crossover_enable,
  output logic strap_indicator_config
);

  logic [`PMP_PIN_W-1:0] pin_s1_q;
  logic [`PMP_PIN_W-1:0] pin_s2_q;
  logic [`PMP_STRAP_W-1:0] strap_cnt_q;
  logic strap_phase;
  logic [`PMP_ADDR_W-1:0] addr_q;
  logic rmii_q;
  logic xover_q;
  logic ledcfg_q;
  logic div10;
  logic tx_rise;
  logic tx_fall;
  logic rx_fall;
  logic rx_upd;
  logic [4:0] rxb_data;
  logic rxb_valid;
  logic rxb_pop;
  logic [3:0] rxb_nib;
  pmp_rx_st_t rx_st_q;
  pmp_rx_st_t rx_st_d;
  logic [3:0] rxd_q;
  logic [3:0] rxd_d;
  logic [1:0] hi_dib_q;
  logic [1:0] hi_dib_d;
  logic dv_q;
  logic dv_d;
  logic er_q;
  logic er_d;
  logic crs_q;
  logic col_q;
  logic tx_en_s;
  logic [3:0] txd_s;
  logic tx_phase_q;
  logic [1:0] tx_lo_q;
  logic [3:0] tx_word_q;
  logic tx_stb_q;
  logic tx_act_q;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // no reset here: the strap capture must see the pins while reset is held
  always_ff @(posedge clk_sys)
  begin
    if (ce)
    begin
      pin_s1_q <= {tx_en, txd, col_i, crs_i, rx_er_i, rx_dv_i, rxd_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign tx_en_s = pin_s2_q[`PMP_SYNC_TXEN];
  assign txd_s = pin_s2_q[`PMP_SYNC_TXD_HI:`PMP_SYNC_TXD_LO];

  // ---------------------------------------------------------------
  // strap window
  // ---------------------------------------------------------------
  // held open a few cycles past release so the synchronisers have settled
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      strap_cnt_q <= '0;
    else if (ce && strap_phase)
      strap_cnt_q <= strap_cnt_q + `PMP_STRAP_W'(1);
  end

  assign strap_phase = (strap_cnt_q != `PMP_STRAP_HOLD);

  // pullups and pulldowns outside set the defaults, giving address one
  always_ff @(posedge clk_sys)
  begin
    if (ce && strap_phase)
    begin
      addr_q <= {pin_s2_q[3:0], pin_s2_q[`PMP_SYNC_COL]};
      rmii_q <= ~pin_s2_q[`PMP_SYNC_DV];
      xover_q <= pin_s2_q[`PMP_SYNC_ER];
      ledcfg_q <= pin_s2_q[`PMP_SYNC_CRS];
    end
  end

  assign phy_addr = addr_q;
  assign rmii_mode = rmii_q;
  assign strap_crossover_enable = xover_q;
  assign strap_indicator_config = ledcfg_q;

  // ---------------------------------------------------------------
  // transmit and receive clocks
  // ---------------------------------------------------------------
  // rmii forces the reference rate; the divide only applies to mii at 10 Mb/s
  assign div10 = ~rmii_q & ~speed_100;

  pmp_clkgen u_txclk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .clk_pin(ref_clock_in),
    .div10(div10),
    .clk_q(tx_clk_o),
    .rise_stb(tx_rise),
    .fall_stb(tx_fall)
  );

  pmp_clkgen u_rxclk (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .clk_pin(rec_clk_in),
    .div10(div10),
    .clk_q(rx_clk_o),
    .rise_stb(),
    .fall_stb(rx_fall)
  );

  // clock pins only face the mac in mii mode
  assign tx_clk_oe = ~strap_phase & ~rmii_q;
  assign rx_clk_oe = ~strap_phase & ~rmii_q;

  // ---------------------------------------------------------------
  // transmit capture
  // ---------------------------------------------------------------
  // sampled on the rising edge the mac sees; in rmii that is the reference
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_phase_q <= 1'b0;
      tx_lo_q <= 2'h0;
      tx_word_q <= `PMP_NIB_ZERO;
      tx_stb_q <= 1'b0;
      tx_act_q <= 1'b0;
    end
    else if (ce)
    begin
      tx_stb_q <= 1'b0;
      if (tx_rise)
      begin
        tx_act_q <= tx_en_s;
        if (!tx_en_s)
          tx_phase_q <= 1'b0;
        else if (!rmii_q)
        begin
          tx_word_q <= txd_s;
          tx_stb_q <= 1'b1;
        end
        else if (!tx_phase_q)
        begin
          tx_lo_q <= txd_s[1:0];
          tx_phase_q <= 1'b1;
        end
        else
        begin
          tx_word_q <= {txd_s[1:0], tx_lo_q};
          tx_stb_q <= 1'b1;
          tx_phase_q <= 1'b0;
        end
      end
    end
  end

  assign tx_out_data = tx_word_q;
  assign tx_out_stb = tx_stb_q;
  assign tx_active = tx_act_q;

  // ---------------------------------------------------------------
  // receive buffer
  // ---------------------------------------------------------------
  // absorbs the gap between core words and the slower mac-side strobes
  pmp_buf2 #(.WIDTH(5)) u_rxbuf (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data({rx_in_err, rx_in_data}),
    .out_valid(rxb_valid),
    .out_ready(rxb_pop),
    .out_data(rxb_data)
  );

  // ---------------------------------------------------------------
  // receive output sequencing
  // ---------------------------------------------------------------
  // lines change on the falling edge so the mac samples a stable rising edge
  assign rx_upd = rmii_q ? tx_fall : rx_fall;
  assign rxb_pop = rx_upd & rxb_valid & (rx_st_q != PMP_RX_DIB_HI);
  // an errored word is inverted, so its crc can never check
  assign rxb_nib = rxb_data[`PMP_RXW_ERR] ? (rxb_data[3:0] ^ `PMP_RX_CORRUPT) : rxb_data[3:0];

  always_comb
  begin
    rx_st_d = rx_st_q;
    rxd_d = rxd_q;
    hi_dib_d = hi_dib_q;
    dv_d = dv_q;
    er_d = er_q;
    if (rx_upd)
    begin
      unique case (rx_st_q)
        PMP_RX_DIB_HI:
        begin
          rxd_d = {2'h0, hi_dib_q};
          rx_st_d = PMP_RX_ACTIVE;
        end
        PMP_RX_IDLE, PMP_RX_ACTIVE:
        begin
          if (rxb_valid)
          begin
            dv_d = 1'b1;
            er_d = rxb_data[`PMP_RXW_ERR];
            rxd_d = rmii_q ? {2'h0, rxb_nib[1:0]} : rxb_nib;
            hi_dib_d = rxb_nib[3:2];
            rx_st_d = rmii_q ? PMP_RX_DIB_HI : PMP_RX_ACTIVE;
          end
          else
          begin
            dv_d = 1'b0;
            er_d = 1'b0;
            rxd_d = `PMP_NIB_ZERO;
            rx_st_d = PMP_RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_st_q <= PMP_RX_IDLE;
      rxd_q <= `PMP_NIB_ZERO;
      hi_dib_q <= 2'h0;
      dv_q <= 1'b0;
      er_q <= 1'b0;
    end
    else if (ce)
    begin
      rx_st_q <= rx_st_d;
      rxd_q <= rxd_d;
      hi_dib_q <= hi_dib_d;
      dv_q <= dv_d;
      er_q <= er_d;
    end
  end

  // ---------------------------------------------------------------
  // carrier sense and collision
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      crs_q <= 1'b0;
      col_q <= 1'b0;
    end
    else if (ce)
    begin
      crs_q <= rmii_q ? (rx_carrier | dv_d) : rx_carrier;
      col_q <= ~rmii_q & ~full_duplex & tx_act_q & rx_carrier;
    end
  end

  // ---------------------------------------------------------------
  // shared pin drive
  // ---------------------------------------------------------------
  // pins stay released while straps are read
  assign rxd_o = rxd_q;
  assign rx_dv_o = dv_q;
  assign rx_er_o = er_q;
  assign crs_o = crs_q;
  assign col_o = col_q;
  assign rxd_oe = ~strap_phase;
  assign rx_dv_oe = ~strap_phase;
  assign rx_er_oe = ~strap_phase;
  assign crs_oe = ~strap_phase;
  assign col_oe = ~strap_phase & ~rmii_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_upd_load;
    rx_upd && rxb_valid && (rx_st_q != PMP_RX_DIB_HI);
  endsequence

  sequence s_err_word;
    rxb_data[`PMP_RXW_ERR] && ce;
  endsequence

  chk_col_full_dup: assert property (ce && !rmii_q && full_duplex |=> !col_o)
    else $error("collision raised in full duplex");
  chk_col_half_dup: assert property (ce && col_o |-> $past(tx_act_q) && $past(rx_carrier))
    else $error("collision without both media active");
  chk_col_rmii_off: assert property (rmii_q && !strap_phase |-> !col_oe && !col_o)
    else $error("collision pin used in rmii");
  chk_txclk_rmii: assert property (rmii_q |-> !tx_clk_oe && !rx_clk_oe)
    else $error("clock pin driven in rmii");
  chk_err_in_pkt: assert property (rx_er_o |-> rx_dv_o)
    else $error("receive error outside a packet");
  chk_err_corrupt: assert property (s_upd_load ##0 s_err_word ##0 !rmii_q |=> rxd_o == ($past(rxb_data[3:0]) ^ `PMP_RX_CORRUPT))
    else $error("errored nibble not corrupted");
  chk_dv_load: assert property (ce ##0 s_upd_load |=> rx_dv_o)
    else $error("valid not raised with data");
  chk_dv_drop: assert property (ce && rx_upd && !rxb_valid && rx_st_q != PMP_RX_DIB_HI |=> !rx_dv_o)
    else $error("valid held with no data");
  chk_crs_mii: assert property (ce && !rmii_q |=> crs_o == $past(rx_carrier))
    else $error("carrier sense not following medium");
  // crs is loaded from the next valid, so both pins move on the same edge
  chk_crs_rmii: assert property (rmii_q && rx_dv_o |-> crs_o)
    else $error("combined carrier pin low during valid data");
  chk_strap_quiet: assert property (strap_phase |-> !rxd_oe && !col_oe && !crs_oe)
    else $error("strap pin driven during capture");
  chk_addr_steady: assert property (!strap_phase |=> $stable(phy_addr))
    else $error("address changed after capture");

endmodule
